// >>> verilog/transcoder_defines.vh
// constants for the infrared biphase transcoder with i2c read-out
`ifndef TRANSCODER_DEFINES_VH
`define TRANSCODER_DEFINES_VH
// ==========================================================
// timing reference
`define REF_CLK_HZ 40000000
`define OSC_HZ 455000
`define BIT_OSC_STD 8'h80
`define BIT_OSC_EXT 8'h40
`define TOL_SHIFT 2
// ==========================================================
// frame lengths, bits after the first start bit
`define NBITS_STD 5'h0d
`define NBITS_EXT 5'h15
// ==========================================================
// i2c
`define SLAVE_ADDR 7'h26
`define NBYTES_STD 2'h2
`define NBYTES_EXT 2'h3
// ==========================================================
// buffer layout
`define BUF_W 24
`define BUF_VALID 23
`define BUF_FMT 22
`define BUF_INPUT 21
// ==========================================================
// apb map
`define REG_STATUS 8'h00
`define REG_BUFFER 8'h04
`define REG_CTRL 8'h08
`define CTRL_ENABLE 0
`define CTRL_FLUSH 1
`define CTRL_RESET 2'h1
`endif

// >>> verilog/ir_biphase_transcoder_i2c.v
// infrared biphase frame decoder, buffer, standby logic and i2c transmitter
// ==========================================================
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "transcoder_defines.vh"

module ir_biphase_transcoder_i2c #(
  parameter OSC_DIV = (`REF_CLK_HZ + `OSC_HZ / 2) / `OSC_HZ
) (
  input wire ref_clk,
  input wire rst,
  input wire ir_fixed_in,
  input wire ir_select_in,
  input wire format_select,
  input wire standby_gate,
  input wire standby_request,
  input wire local_master_addr_bit0,
  input wire local_master_addr_bit1,
  input wire local_master_addr_bit2,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  output wire power_off_out,
  output wire frame_ready_out,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr
);

  localparam D_IDLE = 2'b01;
  localparam D_RUN = 2'b10;
  localparam I_IDLE = 6'b000001;
  localparam I_ADDR = 6'b000010;
  localparam I_LOAD = 6'b000100;
  localparam I_TX = 6'b001000;
  localparam I_AWAIT = 6'b010000;
  localparam I_WSTOP = 6'b100000;

  // ==========================================================
  // input synchronisers
  wire [9:0] pins_raw;
  reg [9:0] meta_reg;
  reg [9:0] sync_reg;
  reg [9:0] prev_reg;
  assign pins_raw = {ir_fixed_in, ir_select_in, format_select, standby_gate,
    standby_request, local_master_addr_bit2, local_master_addr_bit1,
    local_master_addr_bit0, scl_in, sda_in};

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 10'h3ff;
      sync_reg <= 10'h3ff;
      prev_reg <= 10'h3ff;
    end else begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  wire fix_s = sync_reg[9];
  wire sel_s = sync_reg[8];
  wire fmt_s = sync_reg[7];
  wire gate_s = sync_reg[6];
  wire req_s = sync_reg[5];
  wire [2:0] maddr_s = sync_reg[4:2];
  wire scl_s = sync_reg[1];
  wire sda_s = sync_reg[0];
  wire fix_fall = prev_reg[9] & ~fix_s;
  wire sel_fall = prev_reg[8] & ~sel_s;

  // ==========================================================
  // oscillator tick
  reg [7:0] div_reg;
  reg tick_reg;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else if (div_reg == OSC_DIV[7:0] - 8'h01) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  // ==========================================================
  // biphase decoder, time counted in oscillator ticks from last mid edge
  reg [1:0] dstate_reg;
  reg src_reg;
  reg ext_reg;
  reg [7:0] cnt_reg;
  reg [4:0] nbits_reg;
  reg [20:0] shift_reg;
  reg bnd_reg;
  reg done_reg;
  reg [1:0] ctrl_reg;

  wire [7:0] half = ext_reg ? (`BIT_OSC_EXT >> 1) : (`BIT_OSC_STD >> 1);
  wire [7:0] tol = half >> `TOL_SHIFT;
  wire [7:0] full = half << 1;
  wire [7:0] stop_t = full + half;
  wire [4:0] nbits_want = ext_reg ? `NBITS_EXT : `NBITS_STD;
  wire lvl = src_reg ? sel_s : fix_s;
  wire lvl_prev = src_reg ? prev_reg[8] : prev_reg[9];
  wire dedge = lvl ^ lvl_prev;
  wire in_mid = (cnt_reg >= full - tol) && (cnt_reg <= full + tol);
  wire in_bnd = (cnt_reg >= half - tol) && (cnt_reg <= half + tol);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dstate_reg <= D_IDLE;
      src_reg <= 1'b0;
      ext_reg <= 1'b0;
      cnt_reg <= 8'h00;
      nbits_reg <= 5'h00;
      shift_reg <= 21'h00000;
      bnd_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (dstate_reg)
        D_IDLE: begin
          cnt_reg <= 8'h00;
          nbits_reg <= 5'h00;
          bnd_reg <= 1'b0;
          if (ctrl_reg[`CTRL_ENABLE] && fix_fall) begin
            dstate_reg <= D_RUN;
            src_reg <= 1'b0;
            ext_reg <= 1'b0;
          end else if (ctrl_reg[`CTRL_ENABLE] && sel_fall) begin
            dstate_reg <= D_RUN;
            src_reg <= 1'b1;
            ext_reg <= ~fmt_s;
          end
        end
        D_RUN: begin
          if (dedge) begin
            if (in_mid && nbits_reg != nbits_want) begin
              shift_reg <= {shift_reg[19:0], ~lvl};
              nbits_reg <= nbits_reg + 5'h01;
              cnt_reg <= 8'h00;
              bnd_reg <= 1'b0;
            end else if (in_bnd && !bnd_reg) begin
              bnd_reg <= 1'b1;
            end else begin
              dstate_reg <= D_IDLE;
            end
          end else if (cnt_reg > full + tol && nbits_reg != nbits_want) begin
            dstate_reg <= D_IDLE;
          end else if (cnt_reg >= stop_t) begin
            dstate_reg <= D_IDLE;
            done_reg <= lvl;
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        default: dstate_reg <= D_IDLE;
      endcase
    end
  end

  // ==========================================================
  // buffer and standby control
  reg [`BUF_W-1:0] buf_reg;
  reg po_reg;
  reg [5:0] istate_reg;
  reg clr_reg;
  wire busy = (istate_reg == I_LOAD) || (istate_reg == I_TX) ||
    (istate_reg == I_AWAIT);
  wire standby_on = gate_s & ~req_s;
  wire accept = done_reg && !busy &&
    (!buf_reg[`BUF_VALID] || po_reg);
  wire ext_match = ext_reg && shift_reg[16] &&
    (shift_reg[19:17] == maddr_s);
  // ordering keeps the valid bit leftmost for the serial output
  wire [`BUF_W-1:0] buf_new = ext_reg ?
    {1'b1, 1'b1, src_reg, shift_reg[19:0], 1'b0} :
    {1'b1, 1'b0, src_reg, shift_reg[11:0], 9'h000};

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buf_reg <= {`BUF_W{1'b0}};
      po_reg <= 1'b0;
    end else begin
      if (accept) begin
        buf_reg <= buf_new;
      end else if (clr_reg || (psel && penable && pwrite &&
          paddr == `REG_CTRL && pwdata[`CTRL_FLUSH])) begin
        buf_reg[`BUF_VALID] <= 1'b0;
      end
      if (standby_on) begin
        po_reg <= 1'b1;
      end else if (accept && !ext_reg) begin
        po_reg <= 1'b0;
      end else if (done_reg && ext_match) begin
        po_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // i2c slave transmitter
  reg [3:0] ibit_reg;
  reg [1:0] ibyte_reg;
  reg [7:0] ishift_reg;
  reg oe_n_reg;
  reg sda_o_reg;
  wire scl_rise = scl_s & ~prev_reg[1];
  wire scl_fall = ~scl_s & prev_reg[1];
  wire i_start = scl_s & prev_reg[1] & prev_reg[0] & ~sda_s;
  wire i_stop = scl_s & prev_reg[1] & ~prev_reg[0] & sda_s;
  wire [1:0] nbytes = buf_reg[`BUF_FMT] ? `NBYTES_EXT : `NBYTES_STD;
  wire last_byte = (ibyte_reg == nbytes - 2'h1);
  reg [7:0] byte_sel;
  always @* begin
    case (ibyte_reg)
      2'h0: byte_sel = buf_reg[23:16];
      2'h1: byte_sel = buf_reg[15:8];
      default: byte_sel = buf_reg[7:0];
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      istate_reg <= I_IDLE;
      ibit_reg <= 4'h0;
      ibyte_reg <= 2'h0;
      ishift_reg <= 8'h00;
      oe_n_reg <= 1'b1;
      sda_o_reg <= 1'b0;
      clr_reg <= 1'b0;
    end else begin
      clr_reg <= 1'b0;
      if (i_start) begin
        istate_reg <= I_ADDR;
        ibit_reg <= 4'h0;
        oe_n_reg <= 1'b1;
      end else if (i_stop) begin
        istate_reg <= I_IDLE;
        oe_n_reg <= 1'b1;
      end else begin
        case (istate_reg)
          I_IDLE: oe_n_reg <= 1'b1;
          I_ADDR: begin
            if (scl_rise && ibit_reg != 4'h8) begin
              ishift_reg <= {ishift_reg[6:0], sda_s};
              ibit_reg <= ibit_reg + 4'h1;
            end else if (scl_fall && ibit_reg == 4'h8) begin
              if (ishift_reg[7:1] == `SLAVE_ADDR && ishift_reg[0]) begin
                istate_reg <= I_LOAD;
                oe_n_reg <= 1'b0;
                ibyte_reg <= 2'h0;
              end else begin
                istate_reg <= I_WSTOP;
              end
            end
          end
          I_LOAD: begin
            if (scl_fall) begin
              oe_n_reg <= byte_sel[7];
              ishift_reg <= {byte_sel[6:0], 1'b0};
              ibit_reg <= 4'h1;
              istate_reg <= I_TX;
            end
          end
          I_TX: begin
            if (scl_fall && ibit_reg == 4'h8) begin
              oe_n_reg <= 1'b1;
              istate_reg <= I_AWAIT;
            end else if (scl_fall) begin
              oe_n_reg <= ishift_reg[7];
              ishift_reg <= {ishift_reg[6:0], 1'b0};
              ibit_reg <= ibit_reg + 4'h1;
            end
          end
          I_AWAIT: begin
            if (scl_rise) begin
              if (last_byte) begin
                clr_reg <= 1'b1;
                istate_reg <= I_WSTOP;
              end else if (sda_s) begin
                istate_reg <= I_WSTOP;
              end else begin
                ibyte_reg <= ibyte_reg + 2'h1;
                istate_reg <= I_LOAD;
              end
            end
          end
          I_WSTOP: oe_n_reg <= 1'b1;
          default: istate_reg <= I_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // apb slave, zero wait states: answer prepared in the setup cycle
  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg fr_reg;
  wire setup = psel & ~penable;
  wire mapped = (paddr == `REG_STATUS) || (paddr == `REG_BUFFER) ||
    (paddr == `REG_CTRL);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      ctrl_reg <= `CTRL_RESET;
      fr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      fr_reg <= buf_reg[`BUF_VALID];
      if (setup) begin
        pslverr_reg <= ~mapped;
        case (paddr)
          `REG_STATUS: prdata_reg <= {28'h0000000, busy, po_reg,
            dstate_reg[1], buf_reg[`BUF_VALID]};
          `REG_BUFFER: prdata_reg <= {8'h00, buf_reg};
          `REG_CTRL: prdata_reg <= {30'h00000000, 1'b0,
            ctrl_reg[`CTRL_ENABLE]};
          default: prdata_reg <= 32'h00000000;
        endcase
      end
      if (psel && penable && pwrite && paddr == `REG_CTRL) begin
        ctrl_reg <= {1'b0, pwdata[`CTRL_ENABLE]};
      end
    end
  end

  assign sda_out = sda_o_reg;
  assign sda_oe_n = oe_n_reg;
  assign power_off_out = po_reg;
  assign frame_ready_out = fr_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule // ir_biphase_transcoder_i2c

// >>> tb/transcoder_props.sv
// port checker for the ir transcoder
`timescale 1ns/1ps
`include "transcoder_defines.vh"
module transcoder_props (
  input wire ref_clk,
  input wire rst,
  input wire standby_gate,
  input wire standby_request,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire power_off_out,
  input wire frame_ready_out,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  // ======
  // i2c bus tracking
  reg [5:0] hist;
  reg [3:0] cnt;
  reg scl_q, sda_q, refused;
  reg [7:0] sh;
  wire scl_up = scl_in & ~scl_q;
  // start and stop both restart the address count
  wire mark = scl_in & scl_q & (sda_q ^ sda_in);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hist <= 6'h00;
      cnt <= 4'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      refused <= 1'b0;
      sh <= 8'h00;
    end else begin
      hist <= {hist[4:0], standby_gate & ~standby_request};
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (mark) begin
        cnt <= 4'h0;
        refused <= 1'b0;
      end else if (scl_up && cnt != 4'hf) begin
        cnt <= cnt + 4'h1;
        sh <= {sh[6:0], sda_in};
        if (cnt == 4'h7)
          refused <= {sh[6:0], sda_in} != {`SLAVE_ADDR, 1'b1};
      end
    end
  end
  // ======
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_stby;
    (standby_gate && !standby_request) [*4];
  endsequence
  sequence s_ack_slot;
    scl_up && cnt == 4'h8 && !refused;
  endsequence
  chk_reset_low: assert property (
    $fell(rst) |-> !power_off_out && !frame_ready_out)
    else $error("outputs not low after reset");
  chk_po_set: assert property (
    s_stby |-> ##[0:3] power_off_out)
    else $error("power off not raised");
  chk_po_gated: assert property (
    $rose(power_off_out) |-> hist != 6'h00)
    else $error("power off raised without gated request");
  chk_addr_ack: assert property (
    s_ack_slot |-> !sda_oe_n)
    else $error("own read address not acked");
  chk_write_refused: assert property (
    refused |-> sda_oe_n)
    else $error("sda pulled after refused address");
  chk_sda_hold: assert property (
    $changed(sda_oe_n) |-> !scl_in)
    else $error("sda moved while scl high");
  chk_sda_zero: assert property (
    sda_out == 1'b0)
    else $error("sda driven high");
  chk_apb_ready: assert property (
    psel && !penable |=> pready)
    else $error("apb access stalled");
  chk_apb_unmapped: assert property (
    psel && penable && paddr != `REG_STATUS && paddr != `REG_BUFFER &&
    paddr != `REG_CTRL |-> pslverr)
    else $error("unmapped access without error");
  chk_flush_zero: assert property (
    psel && penable && !pwrite && paddr == `REG_CTRL |-> !prdata[1])
    else $error("flush bit reads back set");
endmodule // transcoder_props

// >>> tb/i2c_master_model.sv
// i2c master that reads the transcoder buffer
`timescale 1ns/1ps
module i2c_master_model (
  input wire clk,
  input wire sda,
  output reg scl,
  output reg pull
);
  // ======
  // bus cycles; scl is held still between transfers
  localparam H = 20;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task bit_io(input b, output r);
    begin
      wt(4);
      pull <= !b;
      wt(H);
      scl <= 1'b1;
      wt(H);
      r = sda;
      scl <= 1'b0;
    end
  endtask
  task xfer(input [7:0] a, input [1:0] n, output ack, output [23:0] d);
    integer i, k;
    reg r;
    begin
      d = 24'h000000;
      pull <= 1'b1;
      wt(H);
      scl <= 1'b0;
      for (i = 7; i >= 0; i = i - 1)
        bit_io(a[i], r);
      bit_io(1'b1, ack);
      // no ack or a write ends in stop
      if (!ack && a[0]) begin
        for (k = 0; k < n; k = k + 1) begin
          for (i = 0; i < 8; i = i + 1) begin
            bit_io(1'b1, r);
            d = {d[22:0], r};
          end
          bit_io(k == n - 1, r);
        end
      end
      wt(4);
      pull <= 1'b1;
      wt(H);
      scl <= 1'b1;
      wt(H);
      pull <= 1'b0;
      wt(H);
    end
  endtask
endmodule // i2c_master_model

// >>> tb/ir_biphase_transcoder_i2c_tb.sv
// testbench for the ir biphase transcoder
`timescale 1ns/1ps
`include "transcoder_defines.vh"
module ir_biphase_transcoder_i2c_tb;
  reg ref_clk, rst, ir_fixed_in, ir_select_in, format_select;
  reg standby_gate, standby_request, psel, penable, pwrite;
  reg [2:0] ma;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  reg [23:0] d, exp;
  reg ack, err;
  integer error_cnt, n_compared, cyc;
  wire [31:0] prdata;
  wire scl, pull, sda_out, sda_oe_n, power_off_out, frame_ready_out;
  wire pready, pslverr;
  wire sda = !(pull || (!sda_oe_n && !sda_out));
  ir_biphase_transcoder_i2c #(.OSC_DIV(2)) u_ir_biphase_transcoder_i2c (
    .ref_clk(ref_clk), .rst(rst), .ir_fixed_in(ir_fixed_in),
    .ir_select_in(ir_select_in), .format_select(format_select),
    .standby_gate(standby_gate), .standby_request(standby_request),
    .local_master_addr_bit0(ma[0]), .local_master_addr_bit1(ma[1]),
    .local_master_addr_bit2(ma[2]), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_off_out(power_off_out),
    .frame_ready_out(frame_ready_out), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  i2c_master_model u_i2c_master_model (
    .clk(ref_clk), .sda(sda), .scl(scl), .pull(pull));
  // ======
  // tasks
  task chk(input [31:0] got, input [31:0] want);
    begin
      n_compared = n_compared + 1;
      if (got !== want) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task rd_apb(input [7:0] a);
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= 1'b0;
      paddr <= a;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
        @(posedge ref_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr_apb(input [7:0] a, input [31:0] v);
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= 1'b1;
      paddr <= a;
      pwdata <= v;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
        @(posedge ref_clk);
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
    end
  endtask
  // one biphase frame, start bit first, then idle past the stop time
  task send(input sel, input [21:0] v, input integer n, input integer hc);
    integer i, h;
    begin
      for (i = 2 * n + 1; i >= 0; i = i - 1) begin
        h = v[i / 2] ^ ~i[0];
        if (sel)
          ir_select_in <= h;
        else
          ir_fixed_in <= h;
        repeat (hc) @(posedge ref_clk);
      end
      ir_select_in <= 1'b1;
      ir_fixed_in <= 1'b1;
      repeat (1000) @(posedge ref_clk);
    end
  endtask
  task settle(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // ======
  // sequence
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end
  initial begin
    {error_cnt, n_compared, cyc} = 96'h0;
    {rst, ir_fixed_in, ir_select_in, format_select} = 4'hf;
    {standby_gate, standby_request, psel, penable, pwrite} = 5'h08;
    ma = 3'h5;
    paddr = 8'h00;
    pwdata = 32'h0;
    settle(2);
    rst <= 1'b0;
    settle(4);
    chk(power_off_out, 0);
    chk(frame_ready_out, 0);
    rd_apb(`REG_CTRL);
    chk(rd, 32'h1);
    rd_apb(8'h0c);
    chk({rd[30:0], err}, 32'h1);
    standby_request <= 1'b0;
    settle(10);
    chk(power_off_out, 0);
    standby_gate <= 1'b1;
    settle(10);
    chk(power_off_out, 1);
    standby_request <= 1'b1;
    format_select <= 1'b0;
    send(0, {2'b11, 3'h5, 1'b1, 8'h3c, 8'ha5}, 21, 64);
    chk(frame_ready_out, 0);
    format_select <= 1'b1;
    send(1, {2'b11, 3'h5, 1'b1, 8'h3c, 8'ha5}, 21, 64);
    chk(frame_ready_out, 0);
    format_select <= 1'b0;
    send(1, {2'b11, 3'h2, 1'b1, 8'h3c, 8'ha5}, 21, 64);
    chk({frame_ready_out, power_off_out}, 2'h3);
    send(1, {2'b11, 3'h5, 1'b1, 8'hc3, 8'h5a}, 21, 64);
    chk(power_off_out, 0);
    exp = {3'h7, 3'h5, 1'b1, 8'hc3, 8'h5a, 1'b0};
    rd_apb(`REG_BUFFER);
    chk(rd, exp);
    u_i2c_master_model.xfer(8'h4d, 3, ack, d);
    chk({ack, d}, exp);
    settle(10);
    chk(frame_ready_out, 0);
    format_select <= 1'b1;
    standby_request <= 1'b0;
    settle(10);
    standby_request <= 1'b1;
    exp = {4'h9, 5'h15, 6'h2a, 9'h0};
    send(0, {8'h0, 2'b11, 1'b1, 5'h15, 6'h2a}, 13, 128);
    chk(power_off_out, 0);
    send(0, {8'h0, 2'b11, 1'b0, 5'h0a, 6'h15}, 13, 128);
    rd_apb(`REG_BUFFER);
    chk(rd, exp);
    u_i2c_master_model.xfer(8'h4d, 1, ack, d);
    chk({frame_ready_out, d[7:0]}, {1'b1, exp[23:16]});
    u_i2c_master_model.xfer(8'h4c, 2, ack, d);
    chk(ack, 1);
    u_i2c_master_model.xfer(8'h4d, 2, ack, d);
    chk(d, exp[23:8]);
    settle(10);
    chk(frame_ready_out, 0);
    // decoder disabled: a good frame must leave the buffer empty
    wr_apb(`REG_CTRL, 32'h0);
    chk(err, 0);
    rd_apb(`REG_CTRL);
    chk(rd, 32'h0);
    send(0, {8'h0, 2'b11, 1'b0, 5'h0a, 6'h15}, 13, 128);
    chk(frame_ready_out, 0);
    wr_apb(`REG_CTRL, 32'h1);
    send(0, {8'h0, 2'b11, 1'b0, 5'h0a, 6'h15}, 13, 128);
    chk(frame_ready_out, 1);
    rd_apb(`REG_BUFFER);
    chk(rd, {4'h8, 5'h0a, 6'h15, 9'h0});
    // flush keeps the decoder enabled and empties the buffer
    wr_apb(`REG_CTRL, 32'h3);
    settle(4);
    chk(frame_ready_out, 0);
    test_done;
  end
endmodule // ir_biphase_transcoder_i2c_tb
bind ir_biphase_transcoder_i2c transcoder_props u_transcoder_props (
  .ref_clk(ref_clk), .rst(rst), .standby_gate(standby_gate),
  .standby_request(standby_request), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_off_out(power_off_out),
  .frame_ready_out(frame_ready_out), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
